// ---- src/acs_map.vh ----
// Purpose: constants for the conversion sequencer (bit positions, times, cycle counts)
// Assumes: 200 MHz clock, 5 ns period
// Notes:   least times round up to whole cycles
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// ******************************************************
// clock
// ******************************************************
`define ACS_CLK_PERIOD_NS   5

// ******************************************************
// status word layout
// ******************************************************
`define ACS_BIT_START       0
`define ACS_BIT_BUSY        1
`define ACS_BIT_EXT_EN      4
`define ACS_BIT_OVF_EN      5
`define ACS_BIT_INT_EN      6
`define ACS_BIT_DONE        7
`define ACS_CHAN_LSB        8
`define ACS_CHAN_MSB        13
`define ACS_STATUS_RESET    16'h0000
`define ACS_EXP_FIRST_CHAN  6'h10

// ******************************************************
// times in ns, as printed
// ******************************************************
`define ACS_SETTLE_NS       10000
`define ACS_EXP_SETTLE_NS   30000
`define ACS_CONVERT_NS      12000
`define ACS_APER_EXT_NS     200
`define ACS_APER_OVF_NS     165

// ******************************************************
// derived cycle counts (rounded up)
// ******************************************************
`define ACS_CYC(ns)         (((ns) + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
`define ACS_SETTLE_CYC      `ACS_CYC(`ACS_SETTLE_NS)
`define ACS_EXP_SETTLE_CYC  `ACS_CYC(`ACS_EXP_SETTLE_NS)
`define ACS_CONVERT_CYC     `ACS_CYC(`ACS_CONVERT_NS)
`define ACS_APER_EXT_CYC    `ACS_CYC(`ACS_APER_EXT_NS)
`define ACS_APER_OVF_CYC    `ACS_CYC(`ACS_APER_OVF_NS)

// ******************************************************
// interrupt defaults
// ******************************************************
`define ACS_DEF_PRIORITY    3'h6
`define ACS_DEF_VECTOR      9'h0e0

`endif

// ---- src/acs_fifo.v ----
// Purpose: result buffer, parameterised width and depth
// Assumes: depth is a power of two
// Notes:   read data leave a register one cycle after the pop
`timescale 1ns/1ps
`default_nettype none

module acs_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // clock and reset
    input  wire             clock,
    input  wire             reset,
    // fill side
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    // drain side
    output wire             outValid,
    input  wire             outReady,
    output reg  [WIDTH-1:0] outData_q,
    // fill level
    output wire [AW:0]      level
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wrPtr_q;
    reg [AW:0]      rdPtr_q;
    wire            doPush;
    wire            doPop;

    assign level    = wrPtr_q - rdPtr_q;
    assign inReady  = (level != DEPTH[AW:0]);
    assign outValid = (level != {(AW+1){1'b0}});
    assign doPush   = inValid & inReady;
    assign doPop    = outReady & outValid;

    always @(posedge clock) begin
        if (doPush) begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end

    always @(posedge clock) begin
        if (reset) begin
            wrPtr_q   <= {(AW+1){1'b0}};
            rdPtr_q   <= {(AW+1){1'b0}};
            outData_q <= {WIDTH{1'b0}};
        end else begin
            if (doPush) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (doPop) begin
                rdPtr_q   <= rdPtr_q + 1'b1;
                outData_q <= mem[rdPtr_q[AW-1:0]];
            end
        end
    end

endmodule // acs_fifo
`default_nettype wire

// ---- src/acs_sequencer.v ----
// Purpose: conversion sequencer for a 12-bit converter with input multiplexer
// Assumes: converter data pins stable at the end of conversion time
// Notes:   control and status are plain ports, no bus
// Function
// (RQ1) wait 10 us settling after a new base channel is selected
// (RQ2) software start bit begins a conversion at once
// (RQ3) with overflow enable set, each clock overflow starts a conversion
// (RQ4) with external enable set, external start input starts a conversion
// (RQ5) each conversion takes about 12 us before result is available
// (RQ6) finished conversion sets the completion flag in the status word
// (RQ7) results are held in a buffer so new conversions may start early
// (RQ8) buffer address write goes to test DAC, read returns converted value
// (RQ9) test buffer data drive an 8-bit test DAC
// (RQ10) software waits about 30 us after loading test DAC before reading
// (RQ11) interrupt request only with enable set, raised when completion flag set
// (RQ12) priority defaults to 6 and vector to 340, changeable by straps
// (RQ13) selected input becomes a 12-bit result
// (RQ14) eight differential or sixteen single-ended base channels, one converted at once
// (RQ15) channels 20 to 77 are activated on the expander multiplexer
// (RQ16) expander channels wait 30 us before converting
// (RQ17) sample 200 ns after external start, 165 ns after overflow
// (RQ18) any enabled source triggers; starts during a conversion are ignored
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"

module acs_sequencer #(
    parameter SETTLE_CYCLES     = `ACS_SETTLE_CYC,
    parameter EXP_SETTLE_CYCLES = `ACS_EXP_SETTLE_CYC,
    parameter FIFO_DEPTH        = 16,
    parameter FIFO_AW           = 4
) (
    // clock and reset
    input  wire        clock,
    input  wire        reset,
    // status word
    input  wire        statusWrite,
    input  wire [15:0] statusWrData,
    output wire [15:0] statusRdData,
    // buffer address
    input  wire        bufferRead,
    output wire [11:0] bufferRdData,
    input  wire        testDacWrite,
    input  wire [7:0]  testDacWrData,
    // interrupt
    output wire        bus_request_line,
    output reg  [2:0]  intPriority_q,
    output reg  [8:0]  intVector_q,
    input  wire        strapOverride,
    input  wire [2:0]  strapPriority,
    input  wire [8:0]  strapVector,
    // trigger pins
    input  wire        externalStart,
    input  wire        clockOverflow,
    // front end
    input  wire        diffModeSwitch,
    output reg  [3:0]  baseMuxSel_q,
    output reg         baseMuxEnable_q,
    output reg  [5:0]  expMuxSel_q,
    output reg         expMuxEnable_q,
    output reg         sampleHold_q,
    output reg         convertActive_q,
    input  wire [11:0] adcData,
    output reg  [7:0]  testDac_q
);

    // ******************************************************
    // state codes and widths
    // ******************************************************
    localparam S_IDLE = 2'h0;
    localparam S_APER = 2'h1;
    localparam S_CONV = 2'h2;
    localparam S_PUSH = 2'h3;
    localparam [15:0] CONV_CYC  = `ACS_CONVERT_CYC;
    localparam [15:0] APER_EXT  = `ACS_APER_EXT_CYC;
    localparam [15:0] APER_OVF  = `ACS_APER_OVF_CYC;
    localparam [15:0] SETTLE    = SETTLE_CYCLES;
    localparam [15:0] EXPSETTLE = EXP_SETTLE_CYCLES;

    function isExpander;
        input [5:0] chan;
        begin
            isExpander = (chan >= `ACS_EXP_FIRST_CHAN);
        end
    endfunction

    // ******************************************************
    // pin synchronisers
    // ******************************************************
    reg  [14:0] syncA_q;
    reg  [14:0] syncB_q;
    reg         extPrev_q;
    reg         ovfPrev_q;
    wire        extSync;
    wire        ovfSync;
    wire        diffSync;
    wire [11:0] adcSync;

    always @(posedge clock) begin
        if (reset) begin
            syncA_q   <= 15'h0000;
            syncB_q   <= 15'h0000;
            extPrev_q <= 1'b0;
            ovfPrev_q <= 1'b0;
        end else begin
            syncA_q   <= {diffModeSwitch, clockOverflow, externalStart, adcData};
            syncB_q   <= syncA_q;
            extPrev_q <= extSync;
            ovfPrev_q <= ovfSync;
        end
    end

    assign adcSync  = syncB_q[11:0];
    assign extSync  = syncB_q[12];
    assign ovfSync  = syncB_q[13];
    assign diffSync = syncB_q[14];

    // ******************************************************
    // status word and control bits
    // ******************************************************
    reg        extEn_q;
    reg        ovfEn_q;
    reg        intEn_q;
    reg        done_q;
    reg  [5:0] chan_q;
    reg  [1:0] state_q;
    reg  [1:0] state_d;
    reg [15:0] settleCnt_q;
    reg [15:0] phaseCnt_q;
    reg [15:0] phaseCnt_d;
    reg        pending_q;
    reg [15:0] pendAper_q;
    reg [11:0] result_q;
    wire       busy;
    wire       newChan;
    wire [5:0] wrChan;
    wire       swStart;
    wire       extStartEv;
    wire       ovfStartEv;
    wire       anyStart;
    wire [15:0] startAper;
    wire       finish;
    wire       fifoReady;
    wire       fifoValid;
    wire [FIFO_AW:0] fifoLevel;

    assign wrChan  = statusWrData[`ACS_CHAN_MSB:`ACS_CHAN_LSB];
    assign newChan = statusWrite & (wrChan != chan_q);
    assign busy    = (state_q != S_IDLE);

    // (RQ2) software start bit
    assign swStart    = statusWrite & statusWrData[`ACS_BIT_START];
    // (RQ4) gated external start
    assign extStartEv = extEn_q & extSync & ~extPrev_q;
    // (RQ3) gated clock overflow
    assign ovfStartEv = ovfEn_q & ovfSync & ~ovfPrev_q;
    // (RQ18) any enabled source, a full buffer refuses new starts
    assign anyStart   = (swStart | extStartEv | ovfStartEv) & ~busy & ~pending_q & fifoReady;
    // (RQ17) aperture delay per source
    assign startAper  = extStartEv ? APER_EXT : (ovfStartEv ? APER_OVF : 16'h0001);

    always @(posedge clock) begin
        if (reset) begin
            extEn_q <= 1'b0;
            ovfEn_q <= 1'b0;
            intEn_q <= 1'b0;
            chan_q  <= 6'h00;
        end else if (statusWrite) begin
            extEn_q <= statusWrData[`ACS_BIT_EXT_EN];
            ovfEn_q <= statusWrData[`ACS_BIT_OVF_EN];
            intEn_q <= statusWrData[`ACS_BIT_INT_EN];
            chan_q  <= wrChan;
        end
    end

    // (RQ6) completion flag, set wins over clear
    always @(posedge clock) begin
        if (reset) begin
            done_q <= 1'b0;
        end else if (finish) begin
            done_q <= 1'b1;
        end else if (bufferRead && fifoLevel <= {{FIFO_AW{1'b0}}, 1'b1}) begin
            done_q <= 1'b0;
        end else if (statusWrite && !statusWrData[`ACS_BIT_DONE]) begin
            done_q <= 1'b0;
        end
    end

    assign statusRdData = {2'h0, chan_q, done_q, intEn_q, ovfEn_q, extEn_q, 2'h0, busy, 1'b0};

    // ******************************************************
    // channel select and settling
    // ******************************************************
    // (RQ14) base channel, differential mode folds to eight pairs
    // (RQ15) high channels go to the expander
    always @(posedge clock) begin
        if (reset) begin
            baseMuxSel_q    <= 4'h0;
            baseMuxEnable_q <= 1'b0;
            expMuxSel_q     <= 6'h00;
            expMuxEnable_q  <= 1'b0;
        end else begin
            baseMuxSel_q    <= diffSync ? {1'b0, chan_q[2:0]} : chan_q[3:0];
            baseMuxEnable_q <= ~isExpander(chan_q);
            expMuxSel_q     <= chan_q - `ACS_EXP_FIRST_CHAN;
            expMuxEnable_q  <= isExpander(chan_q);
        end
    end

    // (RQ1) settle after base select
    // (RQ16) longer settle for expander
    always @(posedge clock) begin
        if (reset) begin
            settleCnt_q <= 16'h0000;
        end else if (newChan) begin
            settleCnt_q <= isExpander(wrChan) ? EXPSETTLE : SETTLE;
        end else if (settleCnt_q != 16'h0000) begin
            settleCnt_q <= settleCnt_q - 16'h0001;
        end
    end

    // a start taken while settling waits for the mux, not dropped
    always @(posedge clock) begin
        if (reset) begin
            pending_q  <= 1'b0;
            pendAper_q <= 16'h0001;
        end else if (anyStart && (settleCnt_q != 16'h0000 || newChan)) begin
            pending_q  <= 1'b1;
            pendAper_q <= startAper;
        end else if (pending_q && settleCnt_q == 16'h0000 && !newChan) begin
            pending_q  <= 1'b0;
        end
    end

    // ******************************************************
    // conversion sequence
    // ******************************************************
    always @* begin
        state_d    = state_q;
        phaseCnt_d = phaseCnt_q;
        case (state_q)
            S_IDLE: begin
                if (pending_q && settleCnt_q == 16'h0000 && !newChan) begin
                    state_d    = S_APER;
                    phaseCnt_d = pendAper_q;
                end else if (anyStart && settleCnt_q == 16'h0000 && !newChan) begin
                    state_d    = S_APER;
                    phaseCnt_d = startAper;
                end
            end
            S_APER: begin
                if (phaseCnt_q <= 16'h0001) begin
                    state_d    = S_CONV;
                    phaseCnt_d = CONV_CYC;
                end else begin
                    phaseCnt_d = phaseCnt_q - 16'h0001;
                end
            end
            // (RQ5) fixed conversion time
            S_CONV: begin
                if (phaseCnt_q <= 16'h0001) begin
                    state_d = S_PUSH;
                end else begin
                    phaseCnt_d = phaseCnt_q - 16'h0001;
                end
            end
            S_PUSH: begin
                if (fifoReady) begin
                    state_d = S_IDLE;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    always @(posedge clock) begin
        if (reset) begin
            state_q    <= S_IDLE;
            phaseCnt_q <= 16'h0000;
        end else begin
            state_q    <= state_d;
            phaseCnt_q <= phaseCnt_d;
        end
    end

    // (RQ17) hold pulse at the end of the aperture
    always @(posedge clock) begin
        if (reset) begin
            sampleHold_q    <= 1'b0;
            convertActive_q <= 1'b0;
        end else begin
            sampleHold_q    <= (state_q == S_APER) && (state_d == S_CONV);
            convertActive_q <= (state_d == S_CONV);
        end
    end

    // (RQ13) capture the 12-bit word as conversion ends
    always @(posedge clock) begin
        if (reset) begin
            result_q <= 12'h000;
        end else if (state_q == S_CONV && state_d == S_PUSH) begin
            result_q <= adcSync;
        end
    end

    assign finish = (state_q == S_PUSH) & fifoReady;

    // ******************************************************
    // result buffer and test DAC
    // ******************************************************
    // (RQ7) queued results allow early restart
    // (RQ8) reads pop the converted value
    acs_fifo #(
        .WIDTH (12),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) resultFifo (
        .clock     (clock),
        .reset     (reset),
        .inValid   (state_q == S_PUSH),
        .inReady   (fifoReady),
        .inData    (result_q),
        .outValid  (fifoValid),
        .outReady  (bufferRead),
        .outData_q (bufferRdData),
        .level     (fifoLevel)
    );

    // (RQ9) write side drives the test DAC
    always @(posedge clock) begin
        if (reset) begin
            testDac_q <= 8'h00;
        end else if (testDacWrite) begin
            testDac_q <= testDacWrData;
        end
    end

    // ******************************************************
    // interrupt
    // ******************************************************
    // (RQ11) request gated by enable
    assign bus_request_line = intEn_q & done_q;

    // (RQ12) defaults or straps, caught while reset is held
    always @(posedge clock) begin
        if (reset) begin
            intPriority_q <= strapOverride ? strapPriority : `ACS_DEF_PRIORITY;
            intVector_q   <= strapOverride ? strapVector : `ACS_DEF_VECTOR;
        end
    end

endmodule // acs_sequencer
`default_nettype wire

// ---- test/acs_front_model.sv ----
// Purpose: analog front end model, converter output per selected input
// Assumes: converter output is ready as soon as a channel is selected
// Notes:   value encodes expander flag, channel low bits and test dac level
`timescale 1ns/1ps
`default_nettype none
module acs_front_model (
    // mux selection
    input  wire logic [3:0]  baseMuxSel_q,
    input  wire logic        baseMuxEnable_q,
    input  wire logic [5:0]  expMuxSel_q,
    input  wire logic        expMuxEnable_q,
    // test level and result
    input  wire logic [7:0]  testDac_q,
    output wire logic [11:0] adcData
);
    // nothing selected: a floating input, so never the last good value
    assign adcData = !(baseMuxEnable_q || expMuxEnable_q) ? ~{4'h0, testDac_q} :
                     {expMuxEnable_q, expMuxEnable_q ? expMuxSel_q[2:0] : baseMuxSel_q[2:0], testDac_q};
endmodule // acs_front_model
`default_nettype wire

// ---- test/acs_seq_chk.sv ----
// Purpose: port checks on the sequencer
// Assumes: settle counts handed on by the bind
// Notes:   fill level is an estimate from conversion ends and pops
`timescale 1ns/1ps
`default_nettype none
module acs_seq_chk #(
    parameter SETTLE_CYCLES     = 8,
    parameter EXP_SETTLE_CYCLES = 16
) (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        statusWrite,
    input wire logic [15:0] statusWrData,
    input wire logic [15:0] statusRdData,
    input wire logic        bufferRead,
    input wire logic        bus_request_line,
    input wire logic        testDacWrite,
    input wire logic [7:0]  testDacWrData,
    input wire logic        baseMuxEnable_q,
    input wire logic [5:0]  expMuxSel_q,
    input wire logic        expMuxEnable_q,
    input wire logic        sampleHold_q,
    input wire logic        convertActive_q,
    input wire logic [7:0]  testDac_q
);
    localparam int CONV = 2400;
    logic [11:0] convCnt_q;
    logic [15:0] settle_q;
    logic [4:0]  fill_q;
    logic        conv_q;
    // ******
    // helpers
    // ******
    always_ff @(posedge clock) begin
        if (reset) begin
            convCnt_q <= 12'h000;
            settle_q  <= 16'h0000;
            fill_q    <= 5'h00;
            conv_q    <= 1'b0;
        end else begin
            conv_q    <= convertActive_q;
            convCnt_q <= convertActive_q ? convCnt_q + 12'h001 : 12'h000;
            if (statusWrite && statusWrData[13:8] != statusRdData[13:8])
                settle_q <= (statusWrData[13:8] >= 6'h10) ? 16'(EXP_SETTLE_CYCLES) : 16'(SETTLE_CYCLES);
            else if (settle_q != 16'h0000)
                settle_q <= settle_q - 16'h0001;
            fill_q <= fill_q + {4'h0, conv_q & ~convertActive_q} - {4'h0, bufferRead && fill_q != 5'h00};
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    irq_level_a: assert property (bus_request_line == (statusRdData[6] && statusRdData[7]))
        else $error("request line does not follow enable and done");
    conv_time_a: assert property ($fell(convertActive_q) |-> convCnt_q == CONV)
        else $error("conversion length wrong");
    soft_start_a: assert property (statusWrite && statusWrData[0] && !statusRdData[1] && settle_q == 16'h0000
        && statusWrData[13:8] == statusRdData[13:8] && fill_q < 5'h10 |=> statusRdData[1] ##1 sampleHold_q)
        else $error("software start not taken at once");
    hold_first_a: assert property ($rose(convertActive_q) |-> sampleHold_q)
        else $error("conversion without sample");
    no_restart_a: assert property (convertActive_q && $past(convertActive_q) |-> !sampleHold_q)
        else $error("sample during conversion");
    settle_wait_a: assert property (sampleHold_q |-> settle_q == 16'h0000)
        else $error("sample before settling");
    done_set_a: assert property ($fell(convertActive_q) |-> ##[1:2] statusRdData[7])
        else $error("done not set after conversion");
    exp_route_a: assert property (statusRdData[13:8] >= 6'h10 |=> expMuxEnable_q && !baseMuxEnable_q
        && expMuxSel_q == $past(statusRdData[13:8]) - 6'h10)
        else $error("expander channel not routed");
    base_route_a: assert property (statusRdData[13:8] < 6'h10 |=> baseMuxEnable_q && !expMuxEnable_q)
        else $error("base channel not routed");
    dac_load_a: assert property (testDacWrite |=> testDac_q == $past(testDacWrData))
        else $error("test dac not loaded");
endmodule // acs_seq_chk
bind acs_sequencer acs_seq_chk #(.SETTLE_CYCLES(SETTLE_CYCLES), .EXP_SETTLE_CYCLES(EXP_SETTLE_CYCLES)) acs_seq_chk_i (.*);
`default_nettype wire

// ---- test/testbench.sv ----
// Purpose: self-checking bench for the conversion sequencer
// Assumes: settle counts cut to 8 and 16 cycles
// Notes:   front end model answers at once, no analog lag
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int SET = 8;
    localparam int EXS = 16;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        statusWrite = 1'b0;
    logic [15:0] statusWrData = 16'h0000;
    logic        bufferRead = 1'b0;
    logic        testDacWrite = 1'b0;
    logic [7:0]  testDacWrData = 8'h00;
    logic        strapOverride = 1'b0;
    logic        externalStart = 1'b0;
    logic        clockOverflow = 1'b0;
    logic        diffModeSwitch = 1'b0;
    logic [15:0] statusRdData;
    logic [11:0] bufferRdData, adcData;
    logic        bus_request_line, baseMuxEnable_q, expMuxEnable_q, sampleHold_q, convertActive_q;
    logic [2:0]  intPriority_q;
    logic [8:0]  intVector_q;
    logic [3:0]  baseMuxSel_q;
    logic [5:0]  expMuxSel_q;
    logic [7:0]  testDac_q;
    int          num_errors = 0;
    int          checks_done = 0;
    int          cycles = 0;
    acs_sequencer #(.SETTLE_CYCLES(SET), .EXP_SETTLE_CYCLES(EXS), .FIFO_DEPTH(16), .FIFO_AW(4)) acs_sequencer_i (
        .*, .strapPriority(3'h2), .strapVector(9'h1a4));
    acs_front_model acs_front_model_i (.*);
    always #2.5 clock = ~clock;
    // ******
    // support tasks
    // ******
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // long enough for about 22 conversions plus waits
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic rst(input logic s);
        @(posedge clock);
        strapOverride <= s;
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [15:0] d);
        @(posedge clock);
        statusWrite <= 1'b1;
        statusWrData <= d;
        @(posedge clock);
        statusWrite <= 1'b0;
        #1;
    endtask
    task automatic dac(input logic [7:0] v);
        @(posedge clock);
        testDacWrite <= 1'b1;
        testDacWrData <= v;
        @(posedge clock);
        testDacWrite <= 1'b0;
        #1;
        check("test dac", {8'h00, v}, {8'h00, testDac_q});
    endtask
    task automatic pop(input logic [11:0] e);
        @(posedge clock);
        bufferRead <= 1'b1;
        @(posedge clock);
        bufferRead <= 1'b0;
        #1;
        check("result", {4'h0, e}, {4'h0, bufferRdData});
    endtask
    task automatic hold(output int n);
        n = 0;
        while (sampleHold_q !== 1'b1 && n < 99) begin
            tick(1);
            n++;
        end
    endtask
    task automatic idle;
        int n = 0;
        while (statusRdData[1] !== 1'b0 && n < 3000) begin
            tick(1);
            n++;
        end
        check("idle", 16'h0000, {15'h0000, statusRdData[1]});
    endtask
    task automatic pin(input bit k, input logic v);
        @(posedge clock);
        if (k)
            clockOverflow <= v;
        else
            externalStart <= v;
        #1;
    endtask
    function automatic logic [11:0] ev(input logic [5:0] ch, input logic [7:0] d);
        return {ch >= 6'h10, ch[2:0], d};
    endfunction
    // ******
    // scenarios
    // ******
    task automatic t_reset;
        rst(1'b1);
        check("strap prio", 16'h0002, {13'h0000, intPriority_q});
        check("strap vec", 16'h01a4, {7'h00, intVector_q});
        rst(1'b0);
        check("def prio", 16'h0006, {13'h0000, intPriority_q});
        check("def vec", 16'h00e0, {7'h00, intVector_q});
        check("status", 16'h0000, statusRdData);
        $display("reset test done");
    endtask
    task automatic t_soft;
        int n;
        dac(8'h5a);
        // loop-back level needs this long before it is trusted
        tick(6000);
        wr(16'h0041);
        hold(n);
        check("start delay", 16'h0001, 16'(n));
        n = 0;
        while (convertActive_q === 1'b1 && n < 3000) begin
            tick(1);
            n++;
        end
        check("conv cycles", 16'd2400, 16'(n));
        tick(3);
        check("done irq", 16'h0003, {14'h0000, statusRdData[7], bus_request_line});
        pop(ev(6'h00, 8'h5a));
        check("done clear", 16'h0000, {14'h0000, statusRdData[7], bus_request_line});
        $display("software start test done");
    endtask
    task automatic t_fill;
        wr(16'h0000);
        for (int i = 0; i < 16; i++) begin
            dac(8'(i));
            wr(16'h0001);
            if (i == 0) begin
                tick(100);
                wr(16'h0001);
            end
            idle();
        end
        check("done masked", 16'h0002, {14'h0000, statusRdData[7], bus_request_line});
        // done kept set so only the last pop may clear it
        wr(16'h0081);
        tick(3);
        check("full refuse", 16'h0000, {15'h0000, statusRdData[1]});
        for (int i = 0; i < 16; i++)
            pop(ev(6'h00, 8'(i)));
        check("done drained", 16'h0000, {15'h0000, statusRdData[7]});
        pop(ev(6'h00, 8'h0f));
        $display("buffer test done");
    endtask
    task automatic t_chan;
        logic [5:0] chs [3] = '{6'h03, 6'h15, 6'h3f};
        int n;
        int lim;
        for (int i = 0; i < 3; i++) begin
            lim = (chs[i] >= 6'h10) ? EXS : SET;
            wr({2'b00, chs[i], 8'h01});
            hold(n);
            check("settle", 16'h0001, {15'h0000, n > lim && n <= lim + 4});
            check("exp en", {15'h0000, chs[i] >= 6'h10}, {15'h0000, expMuxEnable_q});
            check("sel", {10'h000, chs[i] >= 6'h10 ? chs[i] - 6'h10 : chs[i]},
                  {10'h000, chs[i] >= 6'h10 ? expMuxSel_q : {2'b00, baseMuxSel_q}});
            idle();
            pop(ev(chs[i], 8'h0f));
        end
        pin(1'b0, 1'b0);
        diffModeSwitch <= 1'b1;
        tick(4);
        wr(16'h0b00);
        tick(3);
        check("diff sel", 16'h0003, {12'h000, baseMuxSel_q});
        diffModeSwitch <= 1'b0;
        wr(16'h0000);
        tick(20);
        $display("channel test done");
    endtask
    task automatic t_trig;
        int n;
        int ap;
        for (int k = 0; k < 2; k++) begin
            ap = k ? 33 : 40;
            pin(k[0], 1'b1);
            tick(4);
            pin(k[0], 1'b0);
            tick(60);
            check("no start", 16'h0000, {15'h0000, statusRdData[1]});
            wr(k ? 16'h0020 : 16'h0010);
            pin(k[0], 1'b1);
            hold(n);
            check("aperture", 16'h0001, {15'h0000, n >= ap - 4 && n <= ap + 8});
            pin(k[0], 1'b0);
            idle();
            pop(ev(6'h00, 8'h0f));
            wr(16'h0000);
        end
        $display("trigger test done");
    endtask
    initial begin
        rst(1'b0);
        t_reset();
        t_soft();
        t_fill();
        t_chan();
        t_trig();
        end_sim();
    end
endmodule // testbench
`default_nettype wire
